// ### design/tcw_pkg.sv
// tcw_pkg: constants for the tdm pseudowire control word block
// assumes: a single 20 MHz packet-side clock and synchronous reset
`default_nettype none

package tcw_pkg;
    // ------------------------------------------------------------
    // control word field positions
    // ------------------------------------------------------------
    localparam int CW_W = 32;
    localparam int ACH_LSB = 0;
    localparam int LFLT_BIT = 4;
    localparam int RLOSS_BIT = 5;
    localparam int MOD_LSB = 6;
    localparam int FRAG_LSB = 8;
    localparam int SLEN_LSB = 10;
    localparam int SEQ_LSB = 16;
    localparam int SEQ_W = 16;
    localparam int SLEN_W = 6;
    localparam logic [3:0] ACH_NIBBLE = 4'h1;
    localparam logic [1:0] MOD_NORMAL = 2'h0;
    localparam logic [1:0] MOD_RDI = 2'h2;
    localparam logic [1:0] FRAG_NONE = 2'h0;
    localparam logic [15:0] SHORT_LIMIT = 16'h0040;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int AW = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_CLR = 4'h3;
    localparam logic [3:0] REG_IRQ_EN = 4'h4;
    localparam logic [3:0] REG_FILL = 4'h5;
    localparam logic [3:0] REG_CNT_LOST = 4'h6;
    localparam logic [3:0] REG_CNT_MISO = 4'h7;
    localparam logic [3:0] REG_CNT_OVR = 4'h8;
    localparam logic [3:0] REG_CNT_UND = 4'h9;
    localparam logic [3:0] REG_TX_SEQ = 4'ha;
    // ctrl bits
    localparam int CTRL_STRUCT = 0;
    localparam int CTRL_CAS = 1;
    localparam int CTRL_PFILL = 2;
    localparam int CTRL_SFILL = 3;
    localparam int CTRL_ADMIN = 4;
    localparam int CTRL_ACH = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [11:0] FILL_RESET = 12'h0ff;
    // interrupt status bits
    localparam int IRQ_W = 5;
    localparam int EV_LOST = 0;
    localparam int EV_MISO = 1;
    localparam int EV_OVR = 2;
    localparam int EV_UND = 3;
    localparam int EV_LOPCHG = 4;

    // circuit status
    typedef enum logic [1:0] {
        ST_UP = 2'b00,
        ST_LOP = 2'b01,
        ST_DOWN = 2'b10
    } tcw_status_e;
endpackage : tcw_pkg

`default_nettype wire

// ### design/tcw_pw_control_word.sv
// tcw_pw_control_word: builds transmit control words and checks
// received ones for a tdm circuit-emulation pseudowire
// assumes: framer gives per-packet strobes, jitter buffer reports
// overrun/underrun as pulses, register master follows a plain port
//
// The implementer's own choices: the address map and strobed register access.
`default_nettype none

module tcw_pw_control_word
    import tcw_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int LOP_CLEAR_PKTS = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [tcw_pkg::AW-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic irq,
    // transmit request from framer side
    input wire logic txStart,
    input wire logic [15:0] txPktLen,
    input wire logic acFault,
    input wire logic acRdi,
    output logic [31:0] txCw,
    output logic txCwValid,
    // receive control word from packet side
    input wire logic rxValid,
    input wire logic [31:0] rxCw,
    output logic rxAccept,
    output logic rxDiscard,
    output logic rxFaultPkt,
    // jitter buffer events
    input wire logic jbOverrun,
    input wire logic jbUnderrun,
    output logic jbDropExcess,
    // payload fill toward tdm side
    input wire logic [7:0] playByte,
    input wire logic [3:0] playSig,
    input wire logic playFault,
    output logic [7:0] tdmByte,
    output logic [3:0] tdmSig,
    // circuit status
    output logic [1:0] circuitStatus
);
    import tcw_pkg::*;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [5:0] ctrl_q;
    logic [11:0] fill_q;
    logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqEn_q, evt;
    logic [CNT_W-1:0] cntLost_q, cntMiso_q, cntOvr_q, cntUnd_q;
    logic [SEQ_W-1:0] txSeq_q, rxExp_q;
    logic rxSeen_q, lop_q, lop_d;
    logic [7:0] lopGood_q;
    logic [31:0] regRdata_q;

    wire logic isStruct = ctrl_q[CTRL_STRUCT];
    wire logic casOn = ctrl_q[CTRL_CAS];
    wire logic adminDown = ctrl_q[CTRL_ADMIN];
    wire logic [7:0] idlePay = fill_q[7:0];
    wire logic [3:0] idleSig = fill_q[11:8];

    wire logic wrCtrl = regWr && (regAddr == REG_CTRL);
    wire logic wrClr = regWr && (regAddr == REG_IRQ_CLR);
    wire logic wrEn = regWr && (regAddr == REG_IRQ_EN);
    wire logic wrFill = regWr && (regAddr == REG_FILL);

    // ------------------------------------------------------------
    // transmit control word
    // ------------------------------------------------------------
    // modifier: only structured, fault-free words may signal rdi
    wire logic [1:0] txMod =
        (isStruct && !acFault && acRdi) ? MOD_RDI : MOD_NORMAL;
    // long packets must carry zero so the far end ignores the field
    wire logic [5:0] txSlen = (txPktLen < SHORT_LIMIT)
        ? txPktLen[SLEN_W-1:0] : 6'h00;
    wire logic [3:0] txLead =
        ctrl_q[CTRL_ACH] ? ACH_NIBBLE : 4'h0;
    logic [31:0] txWord;

    // pack fields at their fixed positions
    always_comb begin
        txWord = 32'h0000_0000;
        txWord[ACH_LSB +: 4] = txLead;
        txWord[LFLT_BIT] = acFault;
        txWord[RLOSS_BIT] = lop_q;
        txWord[MOD_LSB +: 2] = txMod;
        txWord[FRAG_LSB +: 2] = FRAG_NONE;
        txWord[SLEN_LSB +: SLEN_W] = txSlen;
        txWord[SEQ_LSB +: SEQ_W] = txSeq_q;
    end

    // word and sequence register; seq wraps naturally at 16 bits
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            txCw <= 32'h0000_0000;
            txCwValid <= 1'b0;
            txSeq_q <= 16'h0000;
        end else begin
            txCwValid <= txStart;
            if (txStart) begin
                txCw <= txWord;
                txSeq_q <= txSeq_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // receive sequence check
    // ------------------------------------------------------------
    wire logic [SEQ_W-1:0] rxSeq = rxCw[SEQ_LSB +: SEQ_W];
    // signed distance from expected; negative means an old packet
    wire logic [SEQ_W-1:0] rxDiff = rxSeq - rxExp_q;
    wire logic rxBack = rxSeen_q && rxDiff[SEQ_W-1];
    wire logic rxGap = rxSeen_q && !rxDiff[SEQ_W-1]
        && (rxDiff != 16'h0000);
    // no reorder store, so every backward packet is unplaceable
    wire logic rxDrop = rxValid && (rxBack || adminDown);
    wire logic rxTake = rxValid && !rxDrop;
    wire logic lostEv = rxTake && rxGap;
    wire logic misoEv = rxValid && rxBack && !adminDown;

    // expected sequence and accept/discard pulses
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rxExp_q <= 16'h0000;
            rxSeen_q <= 1'b0;
            rxAccept <= 1'b0;
            rxDiscard <= 1'b0;
            rxFaultPkt <= 1'b0;
        end else begin
            rxAccept <= rxTake;
            rxDiscard <= rxDrop;
            rxFaultPkt <= rxTake && rxCw[LFLT_BIT];
            if (rxTake) begin
                rxExp_q <= rxSeq + 16'h0001;
                rxSeen_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // packet loss state
    // ------------------------------------------------------------
    // enter on a loss or underrun; leave after a run of good packets
    always_comb begin
        lop_d = lop_q;
        if (lostEv || jbUnderrun) begin
            lop_d = 1'b1;
        end else if (lop_q && rxTake
                && (lopGood_q >= 8'(LOP_CLEAR_PKTS - 1))) begin
            lop_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            lop_q <= 1'b0;
            lopGood_q <= 8'h00;
        end else begin
            lop_q <= lop_d;
            if (lostEv || jbUnderrun || !lop_q) begin
                lopGood_q <= 8'h00;
            end else if (rxTake) begin
                lopGood_q <= lopGood_q + 8'h01;
            end
        end
    end

    // status: admin down wins over packet loss
    assign circuitStatus = adminDown ? ST_DOWN
        : (lop_q ? ST_LOP : ST_UP);

    // ------------------------------------------------------------
    // fill toward tdm side
    // ------------------------------------------------------------
    wire logic fillNow = playFault || jbUnderrun;
    wire logic [7:0] payFill =
        (isStruct && ctrl_q[CTRL_PFILL]) ? idlePay : 8'hff;
    wire logic [3:0] sigFill =
        ctrl_q[CTRL_SFILL] ? idleSig : 4'hf;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tdmByte <= 8'hff;
            tdmSig <= 4'hf;
            jbDropExcess <= 1'b0;
        end else begin
            tdmByte <= fillNow ? payFill : playByte;
            tdmSig <= (fillNow && isStruct && casOn)
                ? sigFill : playSig;
            jbDropExcess <= jbOverrun;
        end
    end

    // ------------------------------------------------------------
    // event counters, saturating
    // ------------------------------------------------------------
    logic [3:0] cntInc;
    logic [CNT_W-1:0] cntArr [4];
    assign cntInc = {jbUnderrun, jbOverrun, misoEv, lostEv};
    assign cntLost_q = cntArr[0];
    assign cntMiso_q = cntArr[1];
    assign cntOvr_q = cntArr[2];
    assign cntUnd_q = cntArr[3];

    // one counter per event kind except the loss-state change
    for (genvar i = 0; i < 4; i++) begin : g_cnt
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                cntArr[i] <= '0;
            end else if (cntInc[i] && !(&cntArr[i])) begin
                cntArr[i] <= cntArr[i] + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, set wins over clear
    // ------------------------------------------------------------
    assign evt = {(lop_d != lop_q), jbUnderrun, jbOverrun,
        misoEv, lostEv};
    assign irqStat_d = (irqStat_q & ~(wrClr ? regWdata[IRQ_W-1:0]
        : 5'h00)) | evt;
    assign irq = |(irqStat_q & irqEn_q);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irqStat_q <= 5'h00;
            irqEn_q <= 5'h00;
            ctrl_q <= CTRL_RESET;
            fill_q <= FILL_RESET;
        end else begin
            irqStat_q <= irqStat_d;
            if (wrEn) irqEn_q <= regWdata[IRQ_W-1:0];
            if (wrCtrl) ctrl_q <= regWdata[5:0];
            if (wrFill) fill_q <= regWdata[11:0];
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (regAddr)
            REG_CTRL: rdMux = {26'h0, ctrl_q};
            REG_STATUS: rdMux = {29'h0, lop_q, circuitStatus};
            REG_IRQ_STAT: rdMux = {27'h0, irqStat_q};
            REG_IRQ_EN: rdMux = {27'h0, irqEn_q};
            REG_FILL: rdMux = {20'h0, fill_q};
            REG_CNT_LOST: rdMux = 32'(cntLost_q);
            REG_CNT_MISO: rdMux = 32'(cntMiso_q);
            REG_CNT_OVR: rdMux = 32'(cntOvr_q);
            REG_CNT_UND: rdMux = 32'(cntUnd_q);
            REG_TX_SEQ: rdMux = {16'h0, txSeq_q};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            regRdata_q <= 32'h0000_0000;
        end else begin
            regRdata_q <= regRd ? rdMux : 32'h0000_0000;
        end
    end
    assign regRdata = regRdata_q;
endmodule : tcw_pw_control_word

`default_nettype wire

// ### tb/tcw_pw_control_word_sva.sv
// tcw_pw_control_word_sva: port checker for the control word block
// assumes: bound to every instance, single clock, sync reset
`default_nettype none
module tcw_pw_control_word_sva
    import tcw_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // transmit side
    input wire logic txStart,
    input wire logic [15:0] txPktLen,
    input wire logic acFault,
    input wire logic [31:0] txCw,
    input wire logic txCwValid,
    // receive, buffer and playout
    input wire logic rxValid,
    input wire logic rxAccept,
    input wire logic rxDiscard,
    input wire logic jbOverrun,
    input wire logic jbUnderrun,
    input wire logic jbDropExcess,
    input wire logic [7:0] playByte,
    input wire logic playFault,
    input wire logic [7:0] tdmByte,
    input wire logic [1:0] circuitStatus
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [15:0] lastSeq_q;
    logic seen_q;

    // last sequence sent; seen flag cleared by reset so a restart is not a step
    always_ff @(posedge mclk) begin
        if (!reset_n) seen_q <= 1'b0;
        else if (txCwValid) seen_q <= 1'b1;
        if (txCwValid) lastSeq_q <= txCw[31:16];
    end

    a_cw_follows: assert property (txStart |=> txCwValid)
        else $error("no control word after request");
    a_lead_nibble: assert property (txCwValid |-> txCw[3:1] == 3'h0)
        else $error("leading bits not zero");
    a_fault_bit: assert property (txStart |=> txCw[4] == $past(acFault))
        else $error("fault flag does not follow fault");
    a_mod_legal: assert property (
        txCwValid |-> !txCw[6] && !(txCw[4] && txCw[7]))
        else $error("reserved modifier sent");
    a_frag_zero: assert property (txCwValid |-> txCw[9:8] == FRAG_NONE)
        else $error("fragment field not zero");
    a_len_field: assert property (txStart |=> txCw[15:10] ==
        ($past(txPktLen) < 16'd64 ? $past(txPktLen[5:0]) : 6'h0))
        else $error("short length field wrong");
    a_seq_step: assert property (
        txCwValid && seen_q |-> txCw[31:16] == lastSeq_q + 16'h1)
        else $error("sequence did not step by one");
    a_rx_answer: assert property (rxValid |=> rxAccept != rxDiscard)
        else $error("packet not accepted or discarded");
    a_rx_quiet: assert property (
        !rxValid |=> !(rxAccept || rxDiscard))
        else $error("answer without a packet");
    a_drop_excess: assert property (jbOverrun |=> jbDropExcess)
        else $error("overrun not dropped");
    a_play_pass: assert property (
        !playFault && !jbUnderrun |=> tdmByte == $past(playByte))
        else $error("good payload altered");
    a_status_code: assert property (circuitStatus != 2'b11)
        else $error("undefined circuit status");

    c_rdi_sent: cover property (txCwValid && txCw[7]);
    c_discard: cover property (rxDiscard);
    c_overrun: cover property (jbDropExcess);
endmodule : tcw_pw_control_word_sva

bind tcw_pw_control_word tcw_pw_control_word_sva u_sva (
    .mclk(mclk), .reset_n(reset_n), .txStart(txStart),
    .txPktLen(txPktLen), .acFault(acFault), .txCw(txCw),
    .txCwValid(txCwValid), .rxValid(rxValid), .rxAccept(rxAccept),
    .rxDiscard(rxDiscard), .jbOverrun(jbOverrun),
    .jbUnderrun(jbUnderrun), .jbDropExcess(jbDropExcess),
    .playByte(playByte), .playFault(playFault), .tdmByte(tdmByte),
    .circuitStatus(circuitStatus)
);
`default_nettype wire

// ### tb/tcw_remote_end.sv
// tcw_remote_end: far pseudowire endpoint sending control words
// assumes: the bench pulses send for one cycle per packet
`default_nettype none
module tcw_remote_end (
    // clock
    input wire logic mclk,
    // bench request
    input wire logic send,
    input wire logic [15:0] seq,
    input wire logic lBit,
    // packet side toward the block
    output logic rxValid,
    output logic [31:0] rxCw
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rxValid = 1'b0;
    initial rxCw = 32'h5a5a_a5a5;
    // idle word toggles so a stale word never passes for a packet
    always @(posedge mclk) begin
        rxValid <= send;
        if (send) rxCw <= {seq, 11'h0, lBit, 4'h0};
        else rxCw <= ~rxCw;
    end
endmodule : tcw_remote_end
`default_nettype wire

// ### tb/test_tcw_pw_control_word.sv
// test_tcw_pw_control_word: random and corner tests of the block
// assumes: remote endpoint model and bound port checker alongside
`default_nettype none
module test_tcw_pw_control_word
    import tcw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0, irq;
    logic [3:0] regAddr = 4'h0, playSig = 4'h0, tdmSig;
    logic [31:0] regWdata = 32'h0, regRdata, txCw, rxCw;
    logic txStart = 1'b0, acFault = 1'b0, acRdi = 1'b0, txCwValid;
    logic [15:0] txPktLen = 16'h0, seq = 16'h0, txSeq = 16'h0;
    logic rxValid, rxAccept, rxDiscard, rxFaultPkt, send = 1'b0;
    logic lBit = 1'b0, jbOverrun = 1'b0, jbUnderrun = 1'b0, jbDropExcess;
    logic playFault = 1'b0, loss = 1'b0;
    logic [7:0] playByte = 8'h0, tdmByte;
    logic [1:0] circuitStatus;
    logic [5:0] ctl = 6'h0;
    logic [11:0] fill = 12'h0ff;
    int failures = 0, total_checks = 0;
    always #25 mclk = ~mclk;

    tcw_pw_control_word u_dut (.mclk(mclk), .reset_n(reset_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irq(irq), .txStart(txStart),
        .txPktLen(txPktLen), .acFault(acFault), .acRdi(acRdi),
        .txCw(txCw), .txCwValid(txCwValid), .rxValid(rxValid),
        .rxCw(rxCw), .rxAccept(rxAccept), .rxDiscard(rxDiscard),
        .rxFaultPkt(rxFaultPkt), .jbOverrun(jbOverrun),
        .jbUnderrun(jbUnderrun), .jbDropExcess(jbDropExcess),
        .playByte(playByte), .playSig(playSig), .playFault(playFault),
        .tdmByte(tdmByte), .tdmSig(tdmSig), .circuitStatus(circuitStatus));
    tcw_remote_end u_far (.mclk(mclk), .send(send), .seq(seq),
        .lBit(lBit), .rxValid(rxValid), .rxCw(rxCw));

    // ------------------------------------------------------------
    // expectations and bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] cwExp(logic [15:0] n, logic f, logic r);
        logic [1:0] m;
        m = (ctl[CTRL_STRUCT] && !f && r) ? MOD_RDI : MOD_NORMAL;
        cwExp = {txSeq, n < 16'd64 ? n[5:0] : 6'h0, FRAG_NONE, m, loss, f,
            ctl[CTRL_ACH] ? ACH_NIBBLE : 4'h0};
    endfunction : cwExp
    // fill only replaces what the fault marks invalid
    function automatic logic [11:0] playExp(logic [7:0] b, logic [3:0] s,
        logic f);
        playExp = {s, b};
        if (f) playExp[7:0] = (ctl[0] && ctl[2]) ? fill[7:0] : 8'hff;
        if (f && ctl[0] && ctl[1]) playExp[11:8] = ctl[3] ? fill[11:8] : 4'hf;
    endfunction : playExp
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rdChk(logic [3:0] a, logic [31:0] e);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk("reg", e, regRdata);
    endtask : rdChk
    task automatic tx(logic [15:0] n, logic f, logic r);
        @(posedge mclk);
        txStart <= 1'b1;
        txPktLen <= n;
        acFault <= f;
        acRdi <= r;
        @(posedge mclk);
        txStart <= 1'b0;
        #1 chk("cw", cwExp(n, f, r), txCw);
        txSeq++;
    endtask : tx
    task automatic play(logic [7:0] b, logic [3:0] s, logic f);
        @(posedge mclk);
        playByte <= b;
        playSig <= s;
        playFault <= f;
        @(posedge mclk);
        #1 chk("play", playExp(b, s, f), {tdmSig, tdmByte});
    endtask : play
    task automatic rx(logic [15:0] s, logic l, logic acc);
        @(posedge mclk);
        send <= 1'b1;
        seq <= s;
        lBit <= l;
        @(posedge mclk);
        send <= 1'b0;
        @(posedge mclk);
        #1 chk("accept", acc, rxAccept);
        chk("discard", !acc, rxDiscard);
        if (acc) chk("fault", l, rxFaultPkt);
    endtask : rx
    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(32'h9ecf2355));
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        #1 chk("status", ST_UP, circuitStatus);
        rdChk(REG_FILL, 32'h0ff);
        rdChk(REG_IRQ_STAT, 32'h0);
        wr(4'hf, 32'hffff_ffff);
        rdChk(4'hf, 32'h0);
        for (int i = 0; i < 8; i++) begin
            ctl = 6'($urandom_range(0, 15));
            fill = 12'($urandom);
            wr(REG_CTRL, 32'(ctl));
            wr(REG_FILL, 32'(fill));
            tx(16'd63 + 16'(i % 2), 1'($urandom), 1'($urandom));
            repeat (3) tx(16'($urandom_range(0, 200)), 1'($urandom), 1'b1);
            repeat (4) play(8'($urandom), 4'($urandom), 1'($urandom));
        end
        ctl = 6'h20;
        wr(REG_CTRL, 32'(ctl));
        tx(16'd100, 1'b0, 1'b1);
        ctl = 6'h00;
        wr(REG_CTRL, 32'(ctl));
        play(8'h3c, 4'h5, 1'b0);
        wr(REG_IRQ_EN, 32'h1);
        rx(16'd3, 1'b0, 1'b1);
        rx(16'd4, 1'b1, 1'b1);
        rx(16'd6, 1'b0, 1'b1);
        chk("status", ST_LOP, circuitStatus);
        chk("irq", 1'b1, irq);
        loss = 1'b1;
        tx(16'd80, 1'b0, 1'b0);
        wr(REG_IRQ_EN, 32'h0);
        rdChk(REG_IRQ_STAT, 32'h11);
        chk("irq", 1'b0, irq);
        wr(REG_IRQ_EN, 32'h1);
        rdChk(REG_CNT_LOST, 32'h1);
        chk("irq", 1'b1, irq);
        wr(REG_IRQ_CLR, 32'h1);
        rdChk(REG_IRQ_STAT, 32'h10);
        chk("irq", 1'b0, irq);
        rx(16'd5, 1'b0, 1'b0);
        rdChk(REG_CNT_MISO, 32'h1);
        rx(16'd7, 1'b0, 1'b1);
        chk("status", ST_LOP, circuitStatus);
        rx(16'd8, 1'b0, 1'b1);
        chk("status", ST_UP, circuitStatus);
        loss = 1'b0;
        wr(REG_CTRL, 32'h10);
        #1 chk("status", ST_DOWN, circuitStatus);
        rx(16'd9, 1'b0, 1'b0);
        rdChk(REG_CNT_MISO, 32'h1);
        wr(REG_CTRL, 32'h0);
        @(posedge mclk);
        jbOverrun <= 1'b1;
        @(posedge mclk);
        jbOverrun <= 1'b0;
        #1 chk("drop", 1'b1, jbDropExcess);
        rdChk(REG_CNT_OVR, 32'h1);
        @(posedge mclk);
        jbUnderrun <= 1'b1;
        @(posedge mclk);
        jbUnderrun <= 1'b0;
        #1 chk("byte", 8'hff, tdmByte);
        rdChk(REG_CNT_UND, 32'h1);
        chk("status", ST_LOP, circuitStatus);
        close_out();
    end
endmodule : test_tcw_pw_control_word
`default_nettype wire
